// File: verification/cpu_irq_model.sv
// cpu core and interrupt controller model facing the sequencer
`timescale 1ns/1ps
module cpu_irq_model
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // bench requests
  input  wire logic        go,
  input  wire logic [15:0] iset,
  // sequencer status
  input  wire logic [3:0]  mode_out,
  // towards the sequencer
  output logic             sleep_exec,
  output logic [15:0]      irq_pending
);
  // a sleep instruction retires as a one-cycle pulse
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      sleep_exec <= 1'b0;
    else
      sleep_exec <= go;
  // requests stay pending until the cpu runs and takes them
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      irq_pending <= 16'h0;
    else if (iset != 16'h0)
      irq_pending <= irq_pending | iset;
    else if (mode_out <= 4'h2)
      irq_pending <= 16'h0;
endmodule : cpu_irq_model

// File: verification/pmc_monitor.sv
// port-level assertions for the power mode controller
`timescale 1ns/1ps
module pmc_monitor
#(
  parameter logic [17:0] SETTLE_SCALE_SHIFT = 18'h0
)
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       reset_pin_n,
  // cpu side and mode bits
  input wire logic       sleep_exec,
  input wire logic       condition_code_reg_i,
  input wire logic       software_standby_bit,
  input wire logic       low_speed_on_bit,
  input wire logic       medium_speed_on_bit,
  input wire logic       direct_transfer_on_bit,
  input wire logic       timer_a_clock_select_bit,
  input wire logic       direct_irq_enable,
  input wire logic [2:0] settle_time_select,
  // status
  input wire logic [3:0] mode_out,
  input wire logic       reset_hold,
  input wire logic       direct_exc_req
);
  // ==========================================================
  // helper logic
  logic [4:0]  cb;
  logic        dt;
  logic [17:0] stl_r;
  logic [17:0] stl_exp;
  // control bits packed: standby, low, medium, direct, timer select
  assign cb = {software_standby_bit, low_speed_on_bit, medium_speed_on_bit,
               direct_transfer_on_bit, timer_a_clock_select_bit};
  assign dt = direct_irq_enable & ~condition_code_reg_i;
  assign stl_exp = settle_time_select[2] ? (pmc_pkg::SETTLE_128K >> SETTLE_SCALE_SHIFT) :
                   ((pmc_pkg::SETTLE_8K >> SETTLE_SCALE_SHIFT) << settle_time_select[1:0]);
  // length of the current settling stretch
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      stl_r <= 18'h0;
    else if (mode_out == 4'h8)
      stl_r <= stl_r + 18'h1;
    else
      stl_r <= 18'h0;
  // ==========================================================
  // properties
  default clocking dck @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence settle_end;
    mode_out == 4'h8 ##1 mode_out != 4'h8;
  endsequence
  sequence pin_low;
    !reset_pin_n [*5];
  endsequence
  exc_pulse_a: assert property (direct_exc_req |=> !direct_exc_req)
    else $error("direct exception pulse too long");
  hs_to_ms_a: assert property (mode_out == 4'h0 && sleep_exec && cb[4:1] == 4'h3 && dt
    |-> ##[1:3] mode_out == 4'h1) else $error("no direct switch to medium speed");
  ms_to_hs_a: assert property (mode_out == 4'h1 && sleep_exec && cb[4:1] == 4'h1 && dt
    |-> ##[1:3] mode_out == 4'h0) else $error("no direct switch to high speed");
  ms_sleep_a: assert property (mode_out == 4'h1 && sleep_exec && cb[4:3] == 2'h0 && !cb[1]
    |-> ##[1:3] mode_out == (cb[2] ? 4'h4 : 4'h3)) else $error("wrong sleep kind");
  ms_standby_a: assert property (mode_out == 4'h1 && sleep_exec && cb[4:3] == 2'h2
    && cb[1:0] == 2'h0 |-> ##[1:3] mode_out == 4'h5) else $error("standby not entered");
  sub_watch_a: assert property (mode_out == 4'h2 && sleep_exec && cb[4] && cb[1:0] == 2'h1
    |-> ##[1:3] mode_out == 4'h6) else $error("watch not entered from subactive");
  sub_subsleep_a: assert property (mode_out == 4'h2 && sleep_exec && cb[4:3] == 2'h1
    && cb[1:0] == 2'h1 |-> ##[1:3] mode_out == 4'h7) else $error("subsleep not entered");
  mask_hold_a: assert property (mode_out == 4'h5 && condition_code_reg_i
    && $past(condition_code_reg_i) |=> mode_out == 4'h5) else $error("masked wake left standby");
  pin_reset_a: assert property (pin_low |-> reset_hold && mode_out == 4'h0)
    else $error("reset pin did not hold the cpu");
  settle_len_a: assert property (settle_end |-> stl_r + 18'h2 >= stl_exp
    && stl_r <= stl_exp + 18'h2) else $error("settling wait has wrong length");
endmodule : pmc_monitor

bind power_mode_controller pmc_monitor #(.SETTLE_SCALE_SHIFT(SETTLE_SCALE_SHIFT)) u_pmc_monitor
(
  .mclk(mclk), .resetn(resetn), .reset_pin_n(reset_pin_n), .sleep_exec(sleep_exec),
  .condition_code_reg_i(condition_code_reg_i), .software_standby_bit(software_standby_bit),
  .low_speed_on_bit(low_speed_on_bit), .medium_speed_on_bit(medium_speed_on_bit),
  .direct_transfer_on_bit(direct_transfer_on_bit), .direct_irq_enable(direct_irq_enable),
  .timer_a_clock_select_bit(timer_a_clock_select_bit), .settle_time_select(settle_time_select),
  .mode_out(mode_out), .reset_hold(reset_hold), .direct_exc_req(direct_exc_req)
);

// File: verification/power_mode_controller_tb_top.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module power_mode_controller_tb_top;
  // ==========================================================
  // stimulus and observation
  logic        mclk;
  logic        resetn = 1'b0;
  logic        pin_n = 1'b1;
  logic        cc = 1'b0;
  logic        go = 1'b0;
  logic        dir_en = 1'b1;
  logic [4:0]  cb = 5'h00;      // standby, low, medium, direct, timer select
  logic [2:0]  sts = 3'h0;
  logic [15:0] ien = 16'hffff;
  logic [15:0] iset = 16'h0000;
  logic        slp;
  logic [15:0] pend;
  logic [3:0]  mode;
  logic        rhold;
  logic        dexc;
  logic        cen;
  logic        crun;
  logic        crel;
  logic        wexc;
  logic [1:0]  sdiv = 2'h1;     // subactive clock over 4
  logic [1:0]  mdiv = 2'h1;     // medium clock over 16
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          dex_n = 0;
  int          cen_n = 0;
  int          wex_n = 0;
  // settling shortened by 2**10: 8192 states become 8 cycles
  power_mode_controller #(.SETTLE_SCALE_SHIFT(18'h00a)) u_power_mode_controller
  (
    .mclk(mclk), .resetn(resetn), .reset_pin_n(pin_n), .sleep_exec(slp),
    .condition_code_reg_i(cc), .software_standby_bit(cb[4]), .low_speed_on_bit(cb[3]),
    .medium_speed_on_bit(cb[2]), .direct_transfer_on_bit(cb[1]),
    .timer_a_clock_select_bit(cb[0]), .direct_irq_enable(dir_en),
    .subactive_div_select(sdiv), .medium_div_select(mdiv), .settle_time_select(sts),
    .irq_pending(pend), .irq_enable(ien), .mode_out(mode), .cpu_run(crun),
    .clock_released(crel), .cpu_clk_en(cen), .reset_hold(rhold), .direct_exc_req(dexc),
    .wake_exc_req(wexc)
  );
  cpu_irq_model u_cpu_irq_model
  (
    .mclk(mclk), .resetn(resetn), .go(go), .iset(iset), .mode_out(mode),
    .sleep_exec(slp), .irq_pending(pend)
  );
  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // event counts and hang guard on the quiet edge
  always @(negedge mclk)
  begin
    cyc++;
    dex_n += (dexc === 1'b1);
    cen_n += (cen === 1'b1);
    wex_n += (wexc === 1'b1);
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step
  task automatic sleep_op(input logic [4:0] b);
    @(posedge mclk);
    cb <= b;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask : sleep_op
  task automatic wake(input int n);
    @(posedge mclk);
    iset <= 16'h1 << n;
    @(posedge mclk);
    iset <= 16'h0;
  endtask : wake
  task automatic await(input string what, input logic [3:0] m, input int lim);
    int i;
    @(negedge mclk);
    for (i = 0; i < lim && mode !== m; i++)
      @(negedge mclk);
    check(what, mode, m);
  endtask : await
  // ==========================================================
  // scenarios
  task automatic t_direct();
    int d0;
    int c0;
    sleep_op(5'h06);
    d0 = dex_n;
    await("hs to ms", 4'h1, 10);
    @(posedge mclk);
    check("direct exc", dex_n - d0, 32'h1);
    c0 = cen_n;
    repeat (160) @(posedge mclk);
    check("ms clock", (cen_n - c0 >= 9) && (cen_n - c0 <= 11), 32'h1);
    sleep_op(5'h02);
    await("ms to hs", 4'h0, 10);
  endtask : t_direct
  task automatic t_sleep();
    int w0;
    sleep_op(5'h06);
    await("to ms", 4'h1, 10);
    sleep_op(5'h04);
    await("ms sleep", 4'h4, 10);
    check("sleep halt", crun, 32'h0);
    w0 = wex_n;
    wake(pmc_pkg::WK_OTHER);
    await("any wake", 4'h1, 10);
    check("wake exc", wex_n - w0, 32'h1);
    sleep_op(5'h00);
    await("hs sleep", 4'h3, 10);
    wake(pmc_pkg::WK_TIMER_A);
    await("hs wake", 4'h0, 10);
  endtask : t_sleep
  task automatic t_standby();
    int s;
    int n;
    sleep_op(5'h06);
    await("to ms", 4'h1, 10);
    for (s = 0; s < 5; s++)
    begin
      @(posedge mclk);
      sts <= s[2:0];
      sleep_op(5'h14);
      await("standby", 4'h5, 10);
      if (s == 0)
      begin
        @(posedge mclk);
        ien <= 16'hfffd;
        wake(pmc_pkg::WK_EXTERNAL_IRQ_ZERO);
        step(20);
        check("disabled", mode, 4'h5);
        @(posedge mclk);
        cc <= 1'b1;
        ien <= 16'hffff;
        step(20);
        check("masked", mode, 4'h5);
        @(posedge mclk);
        cc <= 1'b0;
      end
      else
        wake(pmc_pkg::WK_IRQ1);
      await("settle", 4'h8, 10);
      check("clock held", crel, 32'h0);
      n = 1;
      while (mode === 4'h8 && n < 300)
      begin
        @(negedge mclk);
        n++;
      end
      check("settle len", (n + 2 >= (8 << s)) && (n <= (8 << s) + 2), 32'h1);
      check("wake ms", mode, 4'h1);
      check("clock out", crel, 32'h1);
    end
  endtask : t_standby
  task automatic t_sub();
    int c0;
    int d0;
    sleep_op(5'h19);
    await("ms watch", 4'h6, 20);
    wake(pmc_pkg::WK_EXTERNAL_IRQ_ZERO);
    await("watch sub", 4'h2, 20);
    c0 = cen_n;
    repeat (80) @(posedge mclk);
    check("sub clock", (cen_n - c0 >= 19) && (cen_n - c0 <= 21), 32'h1);
    sleep_op(5'h09);
    await("subsleep", 4'h7, 10);
    wake(pmc_pkg::WK_INT_LO + 7);
    await("subsleep wake", 4'h2, 10);
    sleep_op(5'h19);
    await("sub watch", 4'h6, 10);
    wake(pmc_pkg::WK_TIMER_A);
    await("timer wake", 4'h2, 20);
    d0 = dex_n;
    sleep_op(5'h13);
    await("sub to hs", 4'h0, 300);
    check("sub dt exc", dex_n - d0, 32'h1);
    sleep_op(5'h1b);
    await("hs to sub", 4'h2, 20);
    sleep_op(5'h17);
    await("sub to ms", 4'h1, 300);
  endtask : t_sub
  task automatic t_refuse();
    @(posedge mclk);
    cc <= 1'b1;
    sleep_op(5'h02);
    step(10);
    check("masked dt", mode === 4'h3 || mode === 4'h4, 32'h1);
    @(posedge mclk);
    cc <= 1'b0;
    wake(pmc_pkg::WK_OTHER);
    step(30);
    check("locked", mode === 4'h3 || mode === 4'h4, 32'h1);
    @(posedge mclk);
    pin_n <= 1'b0;
    step(8);
    check("pin hold", rhold, 32'h1);
    check("pin mode", mode, 4'h0);
    @(posedge mclk);
    pin_n <= 1'b1;
    step(10);
    @(posedge mclk);
    dir_en <= 1'b0;
    sleep_op(5'h06);
    step(10);
    check("no dt irq", mode === 4'h3 || mode === 4'h4, 32'h1);
    wake(pmc_pkg::WK_OTHER);
    step(20);
    check("left sleep", mode === 4'h0 || mode === 4'h1, 32'h1);
  endtask : t_refuse
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // main sequence
  initial
  begin
    step(8);
    check("rst mode", mode, 4'h0);
    check("rst hold", rhold, 32'h1);
    @(posedge mclk);
    resetn <= 1'b1;
    step(10);
    check("boot mode", mode, 4'h0);
    t_direct();
    t_sleep();
    t_standby();
    t_sub();
    t_refuse();
    complete_run();
  end
endmodule : power_mode_controller_tb_top

// File: verilog/pmc_clk_div.sv
// divider producing a one-cycle clock enable pulse
`timescale 1ns/1ps
module pmc_clk_div
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // divider control
  pmc_clk_if.div    cif
);

  logic [5:0] cnt_r;

  // ==========================================================
  // count to ratio, pulse on wrap
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r    <= 6'h00;
      cif.tick <= 1'b0;
    end
    else if (!cif.run)
    begin
      cnt_r    <= 6'h00;
      cif.tick <= 1'b0;
    end
    else if (cnt_r >= cif.ratio - 6'h01)
    begin
      cnt_r    <= 6'h00;
      cif.tick <= 1'b1;
    end
    else
    begin
      cnt_r    <= cnt_r + 6'h01;
      cif.tick <= 1'b0;
    end
  end

endmodule : pmc_clk_div

// File: verilog/pmc_clk_if.sv
// interface carrying divider setup from the sequencer to the divider
`timescale 1ns/1ps
interface pmc_clk_if;
  logic [5:0] ratio;
  logic       run;
  logic       tick;
  modport ctrl (output ratio, output run, input tick);
  modport div  (input ratio, input run, output tick);
endinterface : pmc_clk_if

// File: verilog/pmc_pkg.sv
// shared constants and types for the power mode controller
package pmc_pkg;

  // ==========================================================
  // cpu operating modes
  typedef enum logic [3:0] {
    MODE_ACTIVE_HS,
    MODE_ACTIVE_MS,
    MODE_SUBACTIVE,
    MODE_SLEEP_HS,
    MODE_SLEEP_MS,
    MODE_STANDBY,
    MODE_WATCH,
    MODE_SUBSLEEP,
    MODE_SETTLE
  } pm_mode_t;

  // ==========================================================
  // wake source bit positions in the pending interrupt vector
  localparam int unsigned WAKE_W        = 16;
  localparam int unsigned WK_TIMER_A    = 0;
  localparam int unsigned WK_EXTERNAL_IRQ_ZERO       = 1;
  localparam int unsigned WK_IRQ1       = 2;
  localparam int unsigned WK_IRQ2       = 3;
  localparam int unsigned WK_IRQ3       = 4;
  localparam int unsigned WK_INT_LO     = 5;   // wakeup_int zero..seven at 5..12
  localparam int unsigned WK_OTHER      = 13;  // any other peripheral interrupt

  // ==========================================================
  // settling wait in states (cycles of mclk)
  localparam int unsigned SETTLE_W      = 18;
  localparam logic [17:0] SETTLE_8K     = 18'h02000;
  localparam logic [17:0] SETTLE_16K    = 18'h04000;
  localparam logic [17:0] SETTLE_32K    = 18'h08000;
  localparam logic [17:0] SETTLE_64K    = 18'h10000;
  localparam logic [17:0] SETTLE_128K   = 18'h20000;

  // ==========================================================
  // clock divider ratios
  localparam int unsigned DIV_W         = 6;
  localparam logic [5:0]  SUB_DIV_2     = 6'h02;
  localparam logic [5:0]  SUB_DIV_4     = 6'h04;
  localparam logic [5:0]  SUB_DIV_8     = 6'h08;
  localparam logic [5:0]  MED_DIV_8     = 6'h08;
  localparam logic [5:0]  MED_DIV_16    = 6'h10;
  localparam logic [5:0]  MED_DIV_32    = 6'h20;
  localparam logic [5:0]  MED_DIV_64    = 6'h3f;  // capped at counter width

endpackage : pmc_pkg

// File: verilog/power_mode_controller.sv
// power mode sequencer: sleep decode, wakeup, settling wait, clock select
//
// What this block does
// - watch with low speed on wakes to subactive
// - subsleep wakes to subactive on listed interrupts
// - masked or disabled interrupts never wake
// - subactive sleep with standby and timer select: watch
// - subactive sleep, standby off, low speed: subsleep
// - subactive clock is watch clock over 2/4/8
// - medium speed on wakes to active medium speed
// - medium sleep with standby, no timer: standby
// - medium sleep with standby and timer: watch
// - medium sleep without standby: high or medium sleep
// - reset pin low ends medium speed mode
// - medium clock is system clock by two-bit select
// - direct transfer switches run mode, raises exception
// - direct interrupt disabled: sleep or watch instead
// - masked direct transfer: sleep/watch with no wakeup
// - high speed direct to medium via sleep
// - medium direct to high speed via sleep
// - active direct to subactive via watch
// - subactive direct to high speed after settling
// - subactive direct to medium speed after settling
// - settling select picks 8K..128K state wait
`timescale 1ns/1ps
module power_mode_controller
#(
  parameter logic [17:0] SETTLE_SCALE_SHIFT = 18'h0  // shortens waits in simulation
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        reset_pin_n,
  // cpu side
  input  wire logic        sleep_exec,
  input  wire logic        condition_code_reg_i,
  // mode control bits
  input  wire logic        software_standby_bit,
  input  wire logic        low_speed_on_bit,
  input  wire logic        medium_speed_on_bit,
  input  wire logic        direct_transfer_on_bit,
  input  wire logic        timer_a_clock_select_bit,
  input  wire logic        direct_irq_enable,
  input  wire logic [1:0]  subactive_div_select,
  input  wire logic [1:0]  medium_div_select,
  input  wire logic [2:0]  settle_time_select,
  // interrupts
  input  wire logic [15:0] irq_pending,
  input  wire logic [15:0] irq_enable,
  // status and clock enables
  output logic      [3:0]  mode_out,
  output logic             cpu_run,
  output logic             clock_released,
  output logic             cpu_clk_en,
  output logic             reset_hold,
  output logic             direct_exc_req,
  output logic             wake_exc_req
);

  pmc_clk_if cif ();

  pmc_pkg::pm_mode_t mode_r;
  pmc_pkg::pm_mode_t settle_dst_r;
  logic [17:0]       settle_cnt_r;
  logic              lock_r;       // entered from masked direct transfer
  logic              pin_s1_r;
  logic              pin_s2_r;
  logic              dt_real;      // sleep decodes to one of the direct transfers
  logic              settle_dt_r;  // current settling stretch closes a direct transfer
  logic              settle_done;  // last cycle of a settling stretch
  logic [15:0]       wake_ok;
  logic              wake_watch;
  logic              wake_sub;
  logic              wake_stby;
  logic              wake_any;
  logic [17:0]       settle_len;
  logic              dt_go;
  logic              dt_blocked;

  // ==========================================================
  // reset pin synchroniser
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ==========================================================
  // wake qualification per source group
  always_comb
  begin
    wake_ok    = condition_code_reg_i ? 16'h0000 : (irq_pending & irq_enable);
    wake_watch = wake_ok[pmc_pkg::WK_TIMER_A] | wake_ok[pmc_pkg::WK_EXTERNAL_IRQ_ZERO];
    wake_stby  = wake_ok[pmc_pkg::WK_EXTERNAL_IRQ_ZERO] | wake_ok[pmc_pkg::WK_IRQ1];
    wake_sub   = wake_ok[pmc_pkg::WK_TIMER_A] | (|wake_ok[pmc_pkg::WK_IRQ3:pmc_pkg::WK_EXTERNAL_IRQ_ZERO])
               | (|wake_ok[pmc_pkg::WK_INT_LO+7:pmc_pkg::WK_INT_LO]);
    wake_any   = |wake_ok;
  end

  // ==========================================================
  // settling length from the three-bit select
  always_comb
  begin
    if (settle_time_select[2])
      settle_len = pmc_pkg::SETTLE_128K;
    else
      unique case (settle_time_select[1:0])
        2'b00:   settle_len = pmc_pkg::SETTLE_8K;
        2'b01:   settle_len = pmc_pkg::SETTLE_16K;
        2'b10:   settle_len = pmc_pkg::SETTLE_32K;
        2'b11:   settle_len = pmc_pkg::SETTLE_64K;
      endcase
    settle_len = settle_len >> SETTLE_SCALE_SHIFT;
    if (settle_len == 18'h0)
      settle_len = 18'h1;
  end

  // direct transfer proceeds only when unmasked and enabled
  assign dt_go      = direct_transfer_on_bit & direct_irq_enable & ~condition_code_reg_i;
  assign dt_blocked = direct_transfer_on_bit & ~dt_go;

  // ==========================================================
  // direct transfer decode: only codes that keep the cpu running count,
  // so a direct bit left set on a standby sleep raises no exception
  always_comb
  begin
    dt_real = 1'b0;
    if (sleep_exec && dt_go)
    begin
      if (mode_r == pmc_pkg::MODE_ACTIVE_HS || mode_r == pmc_pkg::MODE_ACTIVE_MS)
      begin
        // high/medium swap through sleep, or down to subactive through watch
        if (!software_standby_bit && !low_speed_on_bit)
          dt_real = 1'b1;
        else if (software_standby_bit && low_speed_on_bit && timer_a_clock_select_bit)
          dt_real = 1'b1;
      end
      else if (mode_r == pmc_pkg::MODE_SUBACTIVE)
      begin
        // back up to an active mode through watch and settling
        if (software_standby_bit && !low_speed_on_bit && timer_a_clock_select_bit)
          dt_real = 1'b1;
      end
    end
  end

  // final count of the settling wait
  assign settle_done = mode_r == pmc_pkg::MODE_SETTLE && settle_cnt_r <= 18'h1;

  // ==========================================================
  // a direct transfer out of subactive completes only after settling,
  // so its exception waits for the end of the stretch
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      settle_dt_r <= 1'b0;
    else if (mode_r != pmc_pkg::MODE_SETTLE)
      settle_dt_r <= dt_real && mode_r == pmc_pkg::MODE_SUBACTIVE;
  end

  // ==========================================================
  // mode sequencer
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r       <= pmc_pkg::MODE_ACTIVE_HS;
      settle_dst_r <= pmc_pkg::MODE_ACTIVE_HS;
      settle_cnt_r <= 18'h0;
      lock_r       <= 1'b0;
    end
    else if (!pin_s2_r)
    begin
      mode_r <= pmc_pkg::MODE_ACTIVE_HS;
      lock_r <= 1'b0;
    end
    else
    begin
      unique case (mode_r)
        pmc_pkg::MODE_ACTIVE_HS, pmc_pkg::MODE_ACTIVE_MS:
        begin
          if (sleep_exec)
          begin
            lock_r <= direct_transfer_on_bit & condition_code_reg_i;
            if (software_standby_bit && timer_a_clock_select_bit)
            begin
              if (dt_go && low_speed_on_bit)
                mode_r <= pmc_pkg::MODE_SUBACTIVE;
              else
                mode_r <= pmc_pkg::MODE_WATCH;
            end
            else if (software_standby_bit && !low_speed_on_bit)
              mode_r <= pmc_pkg::MODE_STANDBY;
            else if (!software_standby_bit && !low_speed_on_bit)
            begin
              if (dt_go)
                mode_r <= medium_speed_on_bit ? pmc_pkg::MODE_ACTIVE_MS
                                              : pmc_pkg::MODE_ACTIVE_HS;
              else
                mode_r <= medium_speed_on_bit ? pmc_pkg::MODE_SLEEP_MS
                                              : pmc_pkg::MODE_SLEEP_HS;
            end
          end
        end
        pmc_pkg::MODE_SUBACTIVE:
        begin
          if (sleep_exec && timer_a_clock_select_bit)
          begin
            lock_r <= direct_transfer_on_bit & condition_code_reg_i;
            if (software_standby_bit && dt_go && !low_speed_on_bit)
            begin
              mode_r       <= pmc_pkg::MODE_SETTLE;
              settle_cnt_r <= settle_len;
              settle_dst_r <= medium_speed_on_bit ? pmc_pkg::MODE_ACTIVE_MS
                                                  : pmc_pkg::MODE_ACTIVE_HS;
            end
            else if (software_standby_bit)
              mode_r <= pmc_pkg::MODE_WATCH;
            else if (low_speed_on_bit)
              mode_r <= pmc_pkg::MODE_SUBSLEEP;
          end
        end
        pmc_pkg::MODE_SLEEP_HS, pmc_pkg::MODE_SLEEP_MS:
        begin
          if (wake_any && !lock_r)
            mode_r <= (mode_r == pmc_pkg::MODE_SLEEP_MS) ? pmc_pkg::MODE_ACTIVE_MS
                                                         : pmc_pkg::MODE_ACTIVE_HS;
        end
        pmc_pkg::MODE_STANDBY:
        begin
          if (wake_stby)
          begin
            mode_r       <= pmc_pkg::MODE_SETTLE;
            settle_cnt_r <= settle_len;
            settle_dst_r <= medium_speed_on_bit ? pmc_pkg::MODE_ACTIVE_MS
                                                : pmc_pkg::MODE_ACTIVE_HS;
          end
        end
        pmc_pkg::MODE_WATCH:
        begin
          if (wake_watch && !lock_r)
          begin
            if (low_speed_on_bit)
              mode_r <= pmc_pkg::MODE_SUBACTIVE;
            else
            begin
              mode_r       <= pmc_pkg::MODE_SETTLE;
              settle_cnt_r <= settle_len;
              settle_dst_r <= medium_speed_on_bit ? pmc_pkg::MODE_ACTIVE_MS
                                                  : pmc_pkg::MODE_ACTIVE_HS;
            end
          end
        end
        pmc_pkg::MODE_SUBSLEEP:
        begin
          if (wake_sub)
            mode_r <= pmc_pkg::MODE_SUBACTIVE;
        end
        pmc_pkg::MODE_SETTLE:
        begin
          if (settle_cnt_r <= 18'h1)
            mode_r <= settle_dst_r;
          else
            settle_cnt_r <= settle_cnt_r - 18'h1;
        end
        default:
          mode_r <= pmc_pkg::MODE_ACTIVE_HS;
      endcase
    end
  end

  // ==========================================================
  // exception request pulses
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      direct_exc_req <= 1'b0;
      wake_exc_req   <= 1'b0;
    end
    else
    begin
      direct_exc_req <= pin_s2_r && ((dt_real && mode_r != pmc_pkg::MODE_SUBACTIVE)
                        || (settle_done && settle_dt_r));
      wake_exc_req   <= pin_s2_r && !lock_r && (
                          ((mode_r == pmc_pkg::MODE_SLEEP_HS || mode_r == pmc_pkg::MODE_SLEEP_MS)
                           && wake_any)
                        || (mode_r == pmc_pkg::MODE_WATCH && wake_watch && low_speed_on_bit)
                        || (mode_r == pmc_pkg::MODE_SUBSLEEP && wake_sub)
                        || (settle_done && !settle_dt_r));
    end
  end

  // ==========================================================
  // divider ratio selection
  always_comb
  begin
    cif.ratio = 6'h01;
    cif.run   = 1'b1;
    if (mode_r == pmc_pkg::MODE_SUBACTIVE || mode_r == pmc_pkg::MODE_SUBSLEEP)
      unique case (subactive_div_select)
        2'b00:   cif.ratio = pmc_pkg::SUB_DIV_8;
        2'b01:   cif.ratio = pmc_pkg::SUB_DIV_4;
        default: cif.ratio = pmc_pkg::SUB_DIV_2;
      endcase
    else if (mode_r == pmc_pkg::MODE_ACTIVE_MS || mode_r == pmc_pkg::MODE_SLEEP_MS)
      unique case (medium_div_select)
        2'b00:   cif.ratio = pmc_pkg::MED_DIV_8;
        2'b01:   cif.ratio = pmc_pkg::MED_DIV_16;
        2'b10:   cif.ratio = pmc_pkg::MED_DIV_32;
        2'b11:   cif.ratio = pmc_pkg::MED_DIV_64;
      endcase
  end

  pmc_clk_div u_div
  (
    .mclk   (mclk),
    .resetn (resetn),
    .cif    (cif)
  );

  // ==========================================================
  // registered outputs
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_out       <= 4'h0;
      cpu_run        <= 1'b0;
      clock_released <= 1'b0;
      cpu_clk_en     <= 1'b0;
      reset_hold     <= 1'b1;
    end
    else
    begin
      mode_out       <= 4'(mode_r);
      cpu_run        <= mode_r == pmc_pkg::MODE_ACTIVE_HS || mode_r == pmc_pkg::MODE_ACTIVE_MS
                        || mode_r == pmc_pkg::MODE_SUBACTIVE;
      clock_released <= mode_r != pmc_pkg::MODE_SETTLE && mode_r != pmc_pkg::MODE_STANDBY;
      cpu_clk_en     <= cif.tick && (mode_r == pmc_pkg::MODE_ACTIVE_HS
                        || mode_r == pmc_pkg::MODE_ACTIVE_MS || mode_r == pmc_pkg::MODE_SUBACTIVE);
      reset_hold     <= !pin_s2_r;
    end
  end

endmodule : power_mode_controller
